// ==== fpu_exc_pkg.sv ====
/*
 * Constants and carrier types for the floating-point nonarithmetic exception unit.
 * Assumes a 32-bit logical address space, a 16-bit status register and 96-bit extended operands.
 */
package fpu_exc_pkg;
	// ----------------------------------------
	// Vectors, frame formats, frame size
	// ----------------------------------------
	localparam logic [7:0] VEC_UNIMPL = 8'h0B;     // Vector 11
	localparam logic [7:0] VEC_UNSUP = 8'h37;      // Vector 55
	localparam logic [3:0] FMT_PRE = 4'h0;
	localparam logic [3:0] FMT_UNIMPL = 4'h2;
	localparam logic [3:0] FMT_POST = 4'h3;
	localparam logic [4:0] UNIMPL_FRAME_WORDS = 5'h1A;  // 26 words
	localparam logic [4:0] NO_FRAME_WORDS = 5'h00;
	// ----------------------------------------
	// Opclasses and status register fields
	// ----------------------------------------
	localparam logic [2:0] OPC_MEM_REG = 3'h0;
	localparam logic [2:0] OPC_REG_REG = 3'h2;
	localparam logic [2:0] OPC_REG_MEM = 3'h3;
	localparam int SR_T1_BIT = 15;
	localparam int SR_T0_BIT = 14;
	localparam int SR_S_BIT = 13;
	localparam int OPND_W = 96;
	localparam int PACK_HI_W = 32;
	localparam int PACK_LO_W = 64;

	typedef enum logic [1:0] {PREC_SINGLE, PREC_DOUBLE, PREC_EXT, PREC_PACKED} prec_t;
	typedef enum logic [1:0] {TAG_NORMAL, TAG_DENORM, TAG_UNNORM} tag_t;

	// One floating-point instruction offered for exception checking
	typedef struct packed {
		logic unimpl;              // Instruction not done in hardware
		logic [2:0] opclass;
		logic [31:0] pc;           // Address of this instruction
		logic [31:0] pc_next;      // Address of the following instruction
		logic [31:0] ea;           // Calculated effective address
		prec_t src_prec;
		tag_t src_tag;
		prec_t dst_prec;
		tag_t dst_tag;
		logic [OPND_W-1:0] src_opnd;
		logic [OPND_W-1:0] dst_opnd;
	} fpu_req_t;

	// Contents handed to the stacking logic and later to the state save
	typedef struct packed {
		logic [3:0] format;
		logic [7:0] vector;
		logic [31:0] pc;
		logic [31:0] ea;
		logic [15:0] sr_copy;
		logic [4:0] words;                           // State save frame length
		logic dst_in_reg;                            // Destination left in FP register
		logic [OPND_W-1:0] exception_operand_temp;
		logic [OPND_W-1:0] destination_operand_temp;
	} exc_frame_t;
endpackage

// ==== fpu_exc_unit.sv ====
/*
 * Nonarithmetic floating-point exception unit: unimplemented instructions and
 * unsupported operand data types, from detection up to the handler start.
 * Assumes decode offers one instruction at a time with req_valid while ready is high,
 * and that the vector fetch, stack push and prefetch engines answer with one-cycle acks.
 */

// Behaviour
// (RL1) Unimplemented instruction stacks address of following instruction as saved PC.
// (RL2) Unimplemented instruction uses vector 11, fetches handler, pushes format 2 frame.
// (RL3) Handler starts only after prefetch has refilled the instruction pipeline.
// (RL4) State save after unimplemented instruction yields a 26-word frame.
// (RL5) Frame holds both operands, except packed source leaves second in register.
// (RL6) Denormal, unnormal extended, or packed format operand raises unsupported data type.
// (RL7) Opclass 010 or 000 unsupported type: pre-instruction exception, format 0 frame.
// (RL8) Opclass 011 unsupported type: immediate post-instruction exception, format 3 frame.
// (RL9) Every unsupported data type exception fetches vector 55.
// (RL10) Denormalized result signals nonmaskable underflow, not unsupported data type.
// (RL11) Denormal or unnormal extended operands copied unaltered into temp fields.
// (RL12) Packed source: upper 32 bits to destination temp, lower 64 to exception temp.
// (RL13) Packed source leaves destination operand in its floating-point register.
// (RL14) Wait for earlier FP instructions and take pending exceptions first; opclass 011 unsupported data type exceptions skip this wait and go straight to S_SR.
// (RL15) Copy status register, enter supervisor mode, clear both trace bits.
// (RL16) Vector entry address is vector table base plus vector times four.
module fpu_exc_unit (
	input wire logic sys_clk,                        // 10 MHz core clock
	input wire logic rst_n,                          // Async reset, active low
	input wire logic req_valid,                      // Instruction offered
	input wire fpu_exc_pkg::fpu_req_t req,           // Offered instruction
	output logic ready,                              // Unit idle, may take req
	input wire logic fpu_busy,                       // Earlier FP instructions in flight
	input wire logic pend_exc,                       // Earlier FP exception pending
	output logic pend_take,                          // Take the pending exception now
	input wire logic result_denorm,                  // Operation produced a denormal result
	output logic underflow_exc,                      // Nonmaskable underflow pulse
	input wire logic [15:0] sr_in,                   // Current status register
	output logic [15:0] sr_new,                      // Status register for the handler
	input wire logic [31:0] vbr,                     // Vector table base
	output logic vec_req,                            // Fetch vector entry
	output logic [31:0] vec_addr,                    // Vector entry address
	input wire logic vec_ack,                        // Entry fetched
	input wire logic [31:0] handler_addr,            // Fetched handler address
	output logic push_req,                           // Push stack frame
	output fpu_exc_pkg::exc_frame_t frame,           // Frame and state save contents
	input wire logic push_ack,                       // Frame pushed
	output logic prefetch_req,                       // Refill pipeline at handler
	input wire logic prefetch_done,                  // Pipeline full
	output logic handler_start,                      // Begin handler, one-cycle pulse
	output logic [31:0] handler_pc                   // Handler entry address
);
	import fpu_exc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_DRAIN, S_SR, S_VEC, S_PUSH, S_FILL} phase_t;

	typedef struct packed {
		phase_t phase;
		logic ready;
		logic pend_take;
		logic underflow_exc;
		logic [15:0] sr_new;
		logic vec_req;
		logic [31:0] vec_addr;
		logic push_req;
		exc_frame_t frame;
		logic prefetch_req;
		logic handler_start;
		logic [31:0] handler_pc;
	} unit_state_t;

	unit_state_t st;
	unit_state_t next_st;
	logic src_unsup;
	logic dst_unsup;
	logic take;

	// ----------------------------------------
	// Data type screening
	// ----------------------------------------
	// (RL6) unsupported type check
	function automatic logic is_unsup(input prec_t p, input tag_t t);
		is_unsup = (p == PREC_PACKED) || (t == TAG_DENORM) || (t == TAG_UNNORM && p == PREC_EXT);
	endfunction

	// Screen both operands; only opclasses with a defined frame are trapped
	always_comb begin
		src_unsup = is_unsup(req.src_prec, req.src_tag);
		dst_unsup = is_unsup(req.dst_prec, req.dst_tag);
		take = req_valid && st.ready && (req.unimpl ||
			((src_unsup || dst_unsup) && (req.opclass == OPC_MEM_REG || req.opclass == OPC_REG_REG ||
			req.opclass == OPC_REG_MEM)));
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.handler_start = 1'b0;
		// (RL10) result denormal goes to underflow
		next_st.underflow_exc = result_denorm;
		case (st.phase)
			S_IDLE: begin
				if (take) begin
					next_st.ready = 1'b0;
					next_st.frame.ea = req.ea;
					// (RL5) (RL11) both operands kept unaltered
					next_st.frame.exception_operand_temp = req.src_opnd;
					next_st.frame.destination_operand_temp = req.dst_opnd;
					next_st.frame.dst_in_reg = 1'b0;
					if (req.src_prec == PREC_PACKED) begin
						// (RL12) packed source split
						next_st.frame.destination_operand_temp = {req.src_opnd[OPND_W-1 -: PACK_HI_W], 64'h0};
						next_st.frame.exception_operand_temp = {32'h0, req.src_opnd[PACK_LO_W-1:0]};
						// (RL13) destination stays in register
						next_st.frame.dst_in_reg = 1'b1;
					end
					if (req.unimpl) begin
						// (RL1) saved PC is next instruction
						next_st.frame.pc = req.pc_next;
						// (RL2) vector 11, format 2
						next_st.frame.vector = VEC_UNIMPL;
						next_st.frame.format = FMT_UNIMPL;
						// (RL4) 26-word state frame
						next_st.frame.words = UNIMPL_FRAME_WORDS;
						next_st.phase = S_DRAIN;
					end else if (req.opclass == OPC_REG_MEM) begin
						// (RL8) post-instruction, no drain wait
						next_st.frame.pc = req.pc_next;
						next_st.frame.format = FMT_POST;
						// (RL9) unsupported type vector
						next_st.frame.vector = VEC_UNSUP;
						next_st.frame.words = NO_FRAME_WORDS;
						next_st.phase = S_SR;
					end else begin
						// (RL7) pre-instruction restarts this instruction
						next_st.frame.pc = req.pc;
						next_st.frame.format = FMT_PRE;
						// (RL9) unsupported type vector
						next_st.frame.vector = VEC_UNSUP;
						next_st.frame.words = NO_FRAME_WORDS;
						next_st.phase = S_DRAIN;
					end
				end
			end
			S_DRAIN: begin
				// (RL14) pending exceptions go first, then drain
				next_st.pend_take = pend_exc;
				if (!pend_exc && !fpu_busy) begin
					next_st.phase = S_SR;
				end
			end
			S_SR: begin
				// (RL15) copy SR, supervisor, trace off
				next_st.frame.sr_copy = sr_in;
				next_st.sr_new = sr_in;
				next_st.sr_new[SR_S_BIT] = 1'b1;
				next_st.sr_new[SR_T1_BIT] = 1'b0;
				next_st.sr_new[SR_T0_BIT] = 1'b0;
				// (RL16) entry address from base
				next_st.vec_addr = vbr + {22'h0, st.frame.vector, 2'b00};
				next_st.vec_req = 1'b1;
				next_st.phase = S_VEC;
			end
			S_VEC: begin
				// (RL2) fetch handler, then push frame
				if (vec_ack) begin
					next_st.handler_pc = handler_addr;
					next_st.vec_req = 1'b0;
					next_st.push_req = 1'b1;
					next_st.phase = S_PUSH;
				end
			end
			S_PUSH: begin
				if (push_ack) begin
					next_st.push_req = 1'b0;
					next_st.prefetch_req = 1'b1;
					next_st.phase = S_FILL;
				end
			end
			S_FILL: begin
				// (RL3) start only with pipeline full
				if (prefetch_done) begin
					next_st.prefetch_req = 1'b0;
					next_st.handler_start = 1'b1;
					next_st.ready = 1'b1;
					next_st.phase = S_IDLE;
				end
			end
			default: begin
				next_st.phase = S_IDLE;
				next_st.ready = 1'b1;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset leaves the unit idle and ready; all outputs come from here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.phase <= S_IDLE;
			st.ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign ready = st.ready;
	assign pend_take = st.pend_take;
	assign underflow_exc = st.underflow_exc;
	assign sr_new = st.sr_new;
	assign vec_req = st.vec_req;
	assign vec_addr = st.vec_addr;
	assign push_req = st.push_req;
	assign frame = st.frame;
	assign prefetch_req = st.prefetch_req;
	assign handler_start = st.handler_start;
	assign handler_pc = st.handler_pc;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_unimpl_saved_pc: assert property (take && req.unimpl |=> st.frame.pc == $past(req.pc_next)) // RL1
		else $error("saved PC is not the next instruction");
	chk_unimpl_vector_fmt: assert property (st.push_req && st.frame.format == FMT_UNIMPL |-> st.frame.vector == VEC_UNIMPL) // RL2
		else $error("unimplemented frame without vector 11");
	chk_start_after_fill: assert property (st.handler_start |-> $past(st.phase) == S_FILL && $past(prefetch_done)) // RL3
		else $error("handler started before pipeline refill");
	chk_frame_words: assert property (st.handler_start && st.frame.format == FMT_UNIMPL |-> st.frame.words == 5'h1A) // RL4
		else $error("unimplemented state frame not 26 words");
	chk_packed_split: assert property (take && req.src_prec == PREC_PACKED |=>
		st.frame.dst_in_reg && st.frame.destination_operand_temp[63:0] == 64'h0 &&
		st.frame.exception_operand_temp[63:0] == $past(req.src_opnd[63:0])) // RL12
		else $error("packed source split wrong");
	chk_pre_format: assert property (take && !req.unimpl && req.opclass != OPC_REG_MEM |=>
		st.frame.format == FMT_PRE && st.phase == S_DRAIN) // RL7
		else $error("pre-instruction exception without format 0");
	chk_post_immediate: assert property (take && !req.unimpl && req.opclass == OPC_REG_MEM |=>
		st.frame.format == FMT_POST && st.phase == S_SR ##1 st.vec_req) // RL8
		else $error("post-instruction exception not immediate format 3");
	chk_unsup_vector: assert property (st.vec_req && st.frame.format != FMT_UNIMPL |-> st.frame.vector == VEC_UNSUP) // RL9
		else $error("unsupported type not on vector 55");
	chk_underflow_pulse: assert property (result_denorm |=> st.underflow_exc) // RL10
		else $error("denormal result without underflow");
	chk_drain_hold: assert property (st.phase == S_DRAIN && (fpu_busy || pend_exc) |=> st.phase == S_DRAIN) // RL14
		else $error("left drain with work outstanding");
	chk_supervisor_entry: assert property ($rose(st.vec_req) |-> st.sr_new[SR_S_BIT] &&
		!st.sr_new[SR_T1_BIT] && !st.sr_new[SR_T0_BIT] && st.frame.sr_copy == $past(sr_in)) // RL15
		else $error("status register not prepared");
	chk_vector_address: assert property ($rose(st.vec_req) |-> st.vec_addr == $past(vbr) + {22'h0, st.frame.vector, 2'b00}) // RL16
		else $error("vector entry address wrong");

	cov_unimpl_flow: cover property (take && req.unimpl ##[1:60] st.handler_start);
	cov_post_flow: cover property (st.push_req && st.frame.format == FMT_POST);
	cov_pending_first: cover property (st.pend_take ##[1:20] st.vec_req);
endmodule

// ==== test_fpu_exc_unit.sv ====
/*
 * Self-checking bench for the floating-point nonarithmetic exception unit.
 * Assumes the unit's own assertions sit inside its file; the bench answers every
 * vector fetch, frame push and prefetch request on the falling edge after it appears.
 */
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
	miscompares++; $display("BAD %s exp %0h got %0h", what, exp, got); end end
module test_fpu_exc_unit;
	timeunit 1ns;
	timeprecision 1ns;
	import fpu_exc_pkg::*;
	logic sys_clk = 0, rst_n = 0, req_valid = 0, fpu_busy = 0, pend_exc = 0, result_denorm = 0;
	logic vec_ack = 0, push_ack = 0, prefetch_done = 0;
	logic ready, pend_take, underflow_exc, vec_req, push_req, prefetch_req, handler_start;
	logic [15:0] sr_in = 16'hC0F3, sr_new;
	logic [31:0] vbr = 32'h0000_1000, handler_addr = 32'h0000_4A00, vec_addr, handler_pc, seen_addr;
	fpu_req_t req = '0;
	exc_frame_t frame;
	int miscompares = 0, num_checks = 0;
	localparam logic [95:0] SRC = 96'h1234_5678_9ABC_DEF0_0F1E_2D3C;
	localparam logic [95:0] DST = 96'h4000_0000_8765_4321_0000_FFFF;
	fpu_exc_unit fpu_exc_unit_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.ready(ready), .fpu_busy(fpu_busy), .pend_exc(pend_exc), .pend_take(pend_take),
		.result_denorm(result_denorm), .underflow_exc(underflow_exc), .sr_in(sr_in), .sr_new(sr_new),
		.vbr(vbr), .vec_req(vec_req), .vec_addr(vec_addr), .vec_ack(vec_ack), .handler_addr(handler_addr),
		.push_req(push_req), .frame(frame), .push_ack(push_ack), .prefetch_req(prefetch_req),
		.prefetch_done(prefetch_done), .handler_start(handler_start), .handler_pc(handler_pc));
	// ----------------------------------------
	// Clock and far-side responders
	// ----------------------------------------
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	// Acks follow each request half a cycle late, so each request stands one edge
	always @(negedge sys_clk) begin
		vec_ack = vec_req;
		push_ack = push_req;
		prefetch_done = prefetch_req;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	function automatic fpu_req_t mk(logic u, logic [2:0] opc, prec_t sp, tag_t st, prec_t dp, tag_t dt);
		fpu_req_t r;
		r = '0;
		r.unimpl = u;
		r.opclass = opc;
		r.pc = 32'h0000_2000;
		r.pc_next = 32'h0000_2004;
		r.ea = 32'h0000_3000;
		r.src_prec = sp;
		r.src_tag = st;
		r.dst_prec = dp;
		r.dst_tag = dt;
		r.src_opnd = SRC;
		r.dst_opnd = DST;
		return r;
	endfunction
	task automatic offer(input fpu_req_t r);
		req = r;
		req_valid = 1;
		@(negedge sys_clk);
		req_valid = 0;
	endtask
	// Follow one exception to handler start and check the common outputs
	task automatic finish(input logic [7:0] vec, input logic [3:0] fmt, input logic [31:0] pc);
		int n;
		n = 0;
		seen_addr = '0;
		while (handler_start !== 1'b1) begin
			if (vec_req === 1'b1)
				seen_addr = vec_addr;
			if (++n > 40) begin
				`CHK("handler_start", 1'b1, 1'b0)
				report_and_stop();
			end
			@(negedge sys_clk);
		end
		`CHK("vec_addr", vbr + {22'h0, vec, 2'h0}, seen_addr)
		`CHK("vector", vec, frame.vector)
		`CHK("format", fmt, frame.format)
		`CHK("pc", pc, frame.pc)
		`CHK("ea", 32'h0000_3000, frame.ea)
		`CHK("handler_pc", handler_addr, handler_pc)
		`CHK("sr_new", (sr_in | 16'h2000) & 16'h3FFF, sr_new)
		`CHK("sr_copy", sr_in, frame.sr_copy)
		`CHK("ready", 1'b1, ready)
		@(negedge sys_clk);
		`CHK("handler_start pulse", 1'b0, handler_start)
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Unimplemented instruction held back by busy unit and a pending exception
	task automatic t_unimpl();
		fpu_busy = 1;
		pend_exc = 1;
		offer(mk(1, 3'h0, PREC_PACKED, TAG_NORMAL, PREC_EXT, TAG_NORMAL));
		repeat (5) @(negedge sys_clk);
		`CHK("vec_req held", 1'b0, vec_req)
		`CHK("pend_take", 1'b1, pend_take)
		pend_exc = 0;
		@(negedge sys_clk);
		fpu_busy = 0;
		finish(8'h0B, 4'h2, 32'h0000_2004);
		`CHK("words", 5'h1A, frame.words)
		`CHK("dst_in_reg unimpl", 1'b1, frame.dst_in_reg)
		$display("test unimpl done");
	endtask
	// Register-to-memory denormal extended: post exception despite busy unit
	task automatic t_post();
		fpu_busy = 1;
		offer(mk(0, 3'h3, PREC_EXT, TAG_DENORM, PREC_EXT, TAG_NORMAL));
		finish(8'h37, 4'h3, 32'h0000_2004);
		`CHK("exception_operand_temp", SRC, frame.exception_operand_temp)
		`CHK("destination_operand_temp", DST, frame.destination_operand_temp)
		`CHK("dst_in_reg post", 1'b0, frame.dst_in_reg)
		fpu_busy = 0;
		$display("test post done");
	endtask
	// Register-to-register packed source: pre exception, operand split
	task automatic t_pre_packed();
		offer(mk(0, 3'h2, PREC_PACKED, TAG_NORMAL, PREC_EXT, TAG_UNNORM));
		finish(8'h37, 4'h0, 32'h0000_2000);
		`CHK("exception_operand_temp low", {32'h0, SRC[63:0]}, frame.exception_operand_temp)
		`CHK("destination_operand_temp high", {SRC[95:64], 64'h0}, frame.destination_operand_temp)
		`CHK("dst_in_reg", 1'b1, frame.dst_in_reg)
		$display("test pre packed done");
	endtask
	// Memory-to-register unnormal extended destination, then single denormal
	task automatic t_pre_unnorm();
		offer(mk(0, 3'h0, PREC_EXT, TAG_NORMAL, PREC_EXT, TAG_UNNORM));
		finish(8'h37, 4'h0, 32'h0000_2000);
		`CHK("destination_operand_temp", DST, frame.destination_operand_temp)
		offer(mk(0, 3'h0, PREC_SINGLE, TAG_DENORM, PREC_EXT, TAG_NORMAL));
		finish(8'h37, 4'h0, 32'h0000_2000);
		`CHK("exception_operand_temp denorm", SRC, frame.exception_operand_temp)
		$display("test pre unnorm done");
	endtask
	// Clean request and denormal result: no trap, only underflow
	task automatic t_no_trap();
		offer(mk(0, 3'h0, PREC_SINGLE, TAG_NORMAL, PREC_EXT, TAG_NORMAL));
		@(negedge sys_clk);
		`CHK("ready clean", 1'b1, ready)
		result_denorm = 1;
		@(negedge sys_clk);
		result_denorm = 0;
		`CHK("underflow", 1'b1, underflow_exc)
		repeat (3) @(negedge sys_clk);
		`CHK("no vec_req", 1'b0, vec_req)
		`CHK("underflow pulse", 1'b0, underflow_exc)
		$display("test no trap done");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(negedge sys_clk);
		rst_n = 1;
		`CHK("ready reset", 1'b1, ready)
		t_unimpl();
		t_post();
		t_pre_packed();
		t_pre_unnorm();
		t_no_trap();
		report_and_stop();
	end
endmodule
